// *** hw/pltc_core.sv ***
// Programmable-length timer counter with mode control, period latch and flags.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps

// ********************************************************************
// Timer counter core
// ********************************************************************
// What this block does
// (RQ1) A 16-bit count register steps up or down on each selected timer tick.
// (RQ2) Software reads and writes the count; a write takes effect at once.
// (RQ3) The clear bit zeroes count, prescaler and count direction.
// (RQ4) Length field limits count to 0FFh, 03FFh, 0FFFh or 0FFFFh.
// (RQ5) Count writes in shorter lengths are right-justified, upper bits zero.
// (RQ6) Source field picks auxiliary, sub-main or one of two external clocks.
// (RQ7) Divider field passes the clock undivided or divided by 2, 4 or 8.
// (RQ8) Counting happens only with nonzero mode and a running clock source.
// (RQ9) Zero period halts up and up/down; a later nonzero load restarts from zero.
// (RQ10) Mode codes: 00 stop, 01 up, 10 continuous, 11 up/down.
// (RQ11) Up mode counts zero to period then restarts; period is latch plus one.
// (RQ12) Entering up mode above the period restarts from zero at once.
// (RQ13) Up mode: channel-zero flag at period, overflow flag on wrap to zero.
// (RQ14) Immediate period load: higher period counted to, lower one rolls to zero.
// (RQ15) Continuous mode wraps at length maximum with overflow flag.
// (RQ16) Up/down mode counts to the period and back, twice the period.
// (RQ17) Flags come only from counting, never from a direct count write.
// (RQ18) Software should halt the timer before reconfiguring it.
// (RQ19) Software reads a running asynchronous count only by majority vote.
// (RQ20) Up/down: channel-zero flag reaching the period, overflow going 1 to 0.
// (RQ21) Count direction is held while halted unless the clear bit resets it; a nonzero period load ending a zero-period halt also resets it.
// (RQ22) Flags stay set until cleared; the clear bit reads back as zero.
module pltc_core
  import pltc_pkg::*;
#(
  parameter int unsigned SRC_N = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire pltc_bus_req_t busReq,
  input wire logic auxClk,
  input wire logic subMainClk,
  input wire logic extClkA,
  input wire logic extClkB,
  output logic [15:0] rdData_q,
  output logic ccFlag_q,
  output logic ovfFlag_q
);

  // ********************************************************************
  // Register decode
  // ********************************************************************
  pltc_ctrl_t ctrl_q;
  pltc_ctrl_t ctrlNew;
  logic [15:0] count_q;
  logic [15:0] period_q;
  logic dirDown_q;
  logic ctrlWr;
  logic statWr;
  logic countWr;
  logic periodWr;
  logic clearWr;
  logic tick;
  logic [15:0] lenMax;
  logic [15:0] incr;
  logic [15:0] top;
  logic [15:0] cntStep;
  logic dirStep;
  logic setCc;
  logic setOvf;
  logic go;
  logic periodRestart;
  logic upEntry;

  assign ctrlWr = busReq.wr && (busReq.addr == PLTC_ADDR_CTRL);
  assign statWr = busReq.wr && (busReq.addr == PLTC_ADDR_STATUS);
  assign countWr = busReq.wr && (busReq.addr == PLTC_ADDR_COUNT);
  assign periodWr = busReq.wr && (busReq.addr == PLTC_ADDR_PERIOD);
  assign clearWr = ctrlWr && busReq.wdata[PLTC_CLEAR_BIT];
  assign ctrlNew = pltc_ctrl_t'(busReq.wdata[PLTC_CTRL_W-1:0]);

  assign lenMax = pltc_len_max(ctrl_q.len); // see (RQ4)
  assign incr = count_q + 16'h0001;
  // A period beyond the length maximum behaves like continuous counting.
  assign top = (period_q > lenMax) ? lenMax : period_q;

  // Restart from zero when a nonzero period follows a halting zero.
  assign periodRestart = periodWr && (period_q == 16'h0000) && (busReq.wdata != 16'h0000) &&
                         ((ctrl_q.mode == PLTC_MODE_UP) ||
                          (ctrl_q.mode == PLTC_MODE_UPDOWN)); // see (RQ9)
  assign upEntry = ctrlWr && (ctrlNew.mode == PLTC_MODE_UP) &&
                   (count_q > period_q); // see (RQ12)

  pltc_prescaler #(
    .SRC_N(SRC_N)
  ) uPrescaler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .srcPins({extClkB, extClkA, subMainClk, auxClk}),
    .srcSel(ctrl_q.src),
    .divSel(ctrl_q.div),
    .divClear(clearWr),
    .tick_q(tick)
  );

  // ********************************************************************
  // Count sequencing
  // ********************************************************************
  always_comb begin
    cntStep = count_q;
    dirStep = dirDown_q;
    setCc = 1'b0;
    setOvf = 1'b0;
    unique case (ctrl_q.mode) // see (RQ10)
      PLTC_MODE_STOP: begin
        cntStep = count_q;
      end
      PLTC_MODE_UP: begin
        if (count_q >= top) begin
          // A period lowered below the count rolls straight to zero.
          cntStep = 16'h0000; // see (RQ11) see (RQ14)
          setOvf = (count_q == top); // see (RQ13)
        end else begin
          cntStep = incr;
          setCc = (incr == period_q); // see (RQ13)
        end
      end
      PLTC_MODE_CONT: begin
        if (count_q >= lenMax) begin
          cntStep = 16'h0000; // see (RQ15)
          setOvf = 1'b1;
        end else begin
          cntStep = incr;
          setCc = (incr == period_q);
        end
      end
      PLTC_MODE_UPDOWN: begin
        if (period_q > lenMax) begin
          cntStep = (count_q >= lenMax) ? 16'h0000 : incr;
          setOvf = (count_q >= lenMax);
          setCc = (count_q < lenMax) && (incr == period_q);
        end else if (!dirDown_q) begin
          if (count_q >= period_q) begin
            dirStep = 1'b1; // see (RQ16)
            cntStep = count_q - 16'h0001;
          end else begin
            cntStep = incr;
            setCc = (incr == period_q); // see (RQ20)
          end
        end else if (count_q <= 16'h0001) begin
          // A new nonzero period within the length maximum, loaded during descent, takes effect only from zero.
          cntStep = 16'h0000;
          dirStep = 1'b0;
          setOvf = (count_q == 16'h0001); // see (RQ20)
        end else begin
          cntStep = count_q - 16'h0001;
        end
      end
    endcase
  end

  // A zero period holds up and up/down modes still.
  assign go = clkEn && tick && (ctrl_q.mode != PLTC_MODE_STOP) &&
              !((ctrl_q.mode != PLTC_MODE_CONT) && (period_q == 16'h0000)); // see (RQ8) see (RQ9)

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_q <= PLTC_COUNT_RESET;
    end else if (clkEn) begin
      if (clearWr) begin
        count_q <= 16'h0000; // see (RQ3)
      end else if (countWr) begin
        count_q <= busReq.wdata & lenMax; // see (RQ2) see (RQ5)
      end else if (periodRestart || upEntry) begin
        count_q <= 16'h0000;
      end else if (go) begin
        count_q <= cntStep; // see (RQ1)
      end
    end
  end

  // Apart from clear and a period restart, direction only moves on counting ticks, so it survives a stop.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dirDown_q <= 1'b0;
    end else if (clkEn) begin
      if (clearWr || periodRestart) begin
        dirDown_q <= 1'b0; // see (RQ3)
      end else if (go && !countWr) begin
        dirDown_q <= dirStep; // see (RQ21)
      end
    end
  end

  // ********************************************************************
  // Configuration and period latch
  // ********************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= PLTC_CTRL_RESET;
    end else if (clkEn && ctrlWr) begin
      ctrl_q <= ctrlNew; // see (RQ6) see (RQ7)
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      period_q <= PLTC_PERIOD_RESET;
    end else if (clkEn && periodWr) begin
      period_q <= busReq.wdata; // see (RQ14)
    end
  end

  // ********************************************************************
  // Flags and read data
  // ********************************************************************
  // Only counting sets a flag, and a set beats a clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ccFlag_q <= 1'b0;
      ovfFlag_q <= 1'b0;
    end else if (clkEn) begin
      ccFlag_q <= (ccFlag_q && !(statWr && busReq.wdata[PLTC_STAT_CC_BIT])) ||
                  (go && !countWr && setCc); // see (RQ17) see (RQ22)
      ovfFlag_q <= (ovfFlag_q && !(statWr && busReq.wdata[PLTC_STAT_OVF_BIT])) ||
                   (go && !countWr && setOvf); // see (RQ17) see (RQ22)
    end
  end

  // The count is read on the core clock; see the majority-vote caveat.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData_q <= PLTC_READ_UNMAPPED;
    end else if (clkEn) begin
      if (busReq.rd) begin
        unique case (busReq.addr)
          PLTC_ADDR_CTRL: rdData_q <= {8'h00, ctrl_q}; // see (RQ22)
          PLTC_ADDR_STATUS: rdData_q <= {14'h0000, ovfFlag_q, ccFlag_q};
          PLTC_ADDR_COUNT: rdData_q <= count_q; // see (RQ2) see (RQ19)
          PLTC_ADDR_PERIOD: rdData_q <= period_q;
          default: rdData_q <= PLTC_READ_UNMAPPED;
        endcase
      end else begin
        rdData_q <= PLTC_READ_UNMAPPED;
      end
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence upWrapCause;
    clkEn && go && (ctrl_q.mode == PLTC_MODE_UP) && (count_q == top) && !busReq.wr;
  endsequence

  sequence wrappedWithFlag;
    (count_q == 16'h0000) && ovfFlag_q;
  endsequence

  chk_count_write: assert property ( // see (RQ5)
    (clkEn && countWr) |=> (count_q == ($past(busReq.wdata) & $past(lenMax))))
    else $error("count write not stored masked");

  chk_clear_effect: assert property ( // see (RQ3)
    (clkEn && clearWr) |=> (count_q == 16'h0000) && !dirDown_q)
    else $error("clear did not zero count and direction");

  chk_stop_holds: assert property ( // see (RQ8)
    (clkEn && (ctrl_q.mode == PLTC_MODE_STOP) && !busReq.wr) |=> $stable(count_q))
    else $error("count moved while stopped");

  chk_up_wrap: assert property ( // see (RQ13)
    upWrapCause |=> wrappedWithFlag)
    else $error("up mode wrap missing");

  chk_cont_wrap: assert property ( // see (RQ15)
    (go && (ctrl_q.mode == PLTC_MODE_CONT) && (count_q == lenMax) && !busReq.wr)
      |=> wrappedWithFlag)
    else $error("continuous wrap missing");

  chk_updown_bottom: assert property ( // see (RQ20)
    (go && (ctrl_q.mode == PLTC_MODE_UPDOWN) && dirDown_q && (period_q <= lenMax) &&
     (count_q == 16'h0001) && !busReq.wr) |=> ovfFlag_q && !dirDown_q && (count_q == 16'h0000))
    else $error("up/down bottom turn missing");

  chk_cc_reach: assert property ( // see (RQ13)
    (go && (ctrl_q.mode == PLTC_MODE_UP) && (incr == period_q) && (count_q < top) &&
     !busReq.wr) |=> ccFlag_q && (count_q == $past(period_q)))
    else $error("channel-zero flag not set on reach");

  chk_zero_halt: assert property ( // see (RQ9)
    (clkEn && (ctrl_q.mode == PLTC_MODE_UP) && (period_q == 16'h0000) && !busReq.wr)
      |=> $stable(count_q))
    else $error("zero period did not halt");

  chk_write_silent: assert property ( // see (RQ17)
    (clkEn && countWr && !ovfFlag_q && !ccFlag_q) |=> !ovfFlag_q && !ccFlag_q)
    else $error("count write raised a flag");

endmodule : pltc_core

// *** common/pltc_pkg.sv ***
// Shared constants, types and helpers of the programmable-length timer core.
package pltc_pkg;

  // ********************************************************************
  // Register map and bus
  // ********************************************************************
  localparam int unsigned PLTC_ADDR_W = 4;
  localparam int unsigned PLTC_DATA_W = 16;
  localparam logic [3:0] PLTC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] PLTC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] PLTC_ADDR_COUNT = 4'h8;
  localparam logic [3:0] PLTC_ADDR_PERIOD = 4'hc;

  // Control word: [1:0] mode, [3:2] divider, [5:4] source, [7:6] length, [8] clear.
  localparam int unsigned PLTC_CTRL_W = 8;
  localparam int unsigned PLTC_CLEAR_BIT = 8;
  // Status word: [0] channel-zero flag, [1] overflow flag, write one to clear.
  localparam int unsigned PLTC_STAT_CC_BIT = 0;
  localparam int unsigned PLTC_STAT_OVF_BIT = 1;

  localparam logic [15:0] PLTC_COUNT_RESET = 16'h0000;
  localparam logic [15:0] PLTC_PERIOD_RESET = 16'h0000;
  localparam logic [15:0] PLTC_READ_UNMAPPED = 16'h0000;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    PLTC_MODE_STOP = 2'h0,
    PLTC_MODE_UP = 2'h1,
    PLTC_MODE_CONT = 2'h2,
    PLTC_MODE_UPDOWN = 2'h3
  } pltc_mode_t;

  typedef enum logic [1:0] {
    PLTC_LEN_16 = 2'h0,
    PLTC_LEN_12 = 2'h1,
    PLTC_LEN_10 = 2'h2,
    PLTC_LEN_8 = 2'h3
  } pltc_len_t;

  typedef struct packed {
    pltc_len_t len;
    logic [1:0] src;
    logic [1:0] div;
    pltc_mode_t mode;
  } pltc_ctrl_t;

  localparam pltc_ctrl_t PLTC_CTRL_RESET = '{PLTC_LEN_16, 2'h0, 2'h0, PLTC_MODE_STOP};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } pltc_bus_req_t;

  // Largest count that the selected length allows.
  function automatic logic [15:0] pltc_len_max(input pltc_len_t len);
    unique case (len)
      PLTC_LEN_8: pltc_len_max = 16'h00ff;
      PLTC_LEN_10: pltc_len_max = 16'h03ff;
      PLTC_LEN_12: pltc_len_max = 16'h0fff;
      PLTC_LEN_16: pltc_len_max = 16'hffff;
    endcase
  endfunction : pltc_len_max

endpackage : pltc_pkg

// *** hw/pltc_prescaler.sv ***
// Clock source selection, synchronisation and 1/2/4/8 input divider.
`timescale 1ns/1ps
module pltc_prescaler
  import pltc_pkg::*;
#(
  parameter int unsigned SRC_N = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [SRC_N-1:0] srcPins,
  input wire logic [1:0] srcSel,
  input wire logic [1:0] divSel,
  input wire logic divClear,
  output logic tick_q
);

  logic [SRC_N-1:0] sync1_q;
  logic [SRC_N-1:0] sync2_q;
  logic selPrev_q;
  logic [2:0] divCnt_q;
  logic risingEdge;
  logic [2:0] divMask;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clkEn) begin
      sync1_q <= srcPins;
      sync2_q <= sync1_q;
    end
  end

  always_comb begin
    unique case (divSel)
      2'h0: divMask = 3'h0;
      2'h1: divMask = 3'h1;
      2'h2: divMask = 3'h3;
      2'h3: divMask = 3'h7;
    endcase
  end

  // A stopped source gives no edge, so the counter cannot advance.
  assign risingEdge = sync2_q[srcSel] & ~selPrev_q; // see (RQ6) see (RQ8)

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      selPrev_q <= 1'b0;
    end else if (clkEn) begin
      selPrev_q <= sync2_q[srcSel];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else if (clkEn) begin
      if (divClear) begin
        divCnt_q <= 3'h0; // see (RQ3)
        tick_q <= 1'b0;
      end else begin
        if (risingEdge) begin
          divCnt_q <= divCnt_q + 3'h1;
        end
        tick_q <= risingEdge && ((divCnt_q & divMask) == divMask); // see (RQ7)
      end
    end
  end

endmodule : pltc_prescaler

// *** bench/pltc_core_tb_top.sv ***
// Self-checking register-level testbench of the timer counter core.
`timescale 1ns/1ps
module pltc_core_tb_top
  import pltc_pkg::*;
;
  // ********************************************************************
  // Stimulus, tasks and tests
  // ********************************************************************
  logic core_clk;
  logic rst_n;
  logic clkEn;
  pltc_bus_req_t busReq;
  logic [3:0] srcPins;
  logic [15:0] rdData_q;
  logic ccFlag_q;
  logic ovfFlag_q;
  int mismatches;
  int n_compared;

  pltc_core dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .busReq(busReq),
    .auxClk(srcPins[0]),
    .subMainClk(srcPins[1]),
    .extClkA(srcPins[2]),
    .extClkB(srcPins[3]),
    .rdData_q(rdData_q),
    .ccFlag_q(ccFlag_q),
    .ovfFlag_q(ovfFlag_q)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("Compared %0d values, %0d mismatches", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] addr, input logic [15:0] data);
    @(posedge core_clk);
    busReq <= '{1'b1, 1'b0, addr, data};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask : wr

  task automatic chk(input logic [3:0] addr, input logic [15:0] exp);
    @(posedge core_clk);
    busReq <= '{1'b0, 1'b1, addr, 16'h0000};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1;
    check(rdData_q, exp);
  endtask : chk

  // The source runs at one ninth of the core rate, well below the synchroniser limit.
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      @(posedge core_clk);
      srcPins <= srcPins | (4'h1 << s);
      repeat (4) @(posedge core_clk);
      srcPins <= srcPins & ~(4'h1 << s);
      repeat (4) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask : pulse

  task automatic flags(input logic cc, input logic ovf);
    #1;
    check({14'h0000, ovfFlag_q, ccFlag_q}, {14'h0000, ovf, cc});
  endtask : flags

  function automatic logic [15:0] cw(input logic [1:0] m, input logic [1:0] d,
                                     input logic [1:0] s, input logic [1:0] l);
    cw = {8'h00, l, s, d, m};
  endfunction : cw

  function automatic logic [15:0] lenMax(input logic [1:0] l);
    case (l)
      2'h0: lenMax = 16'hffff;
      2'h1: lenMax = 16'h0fff;
      2'h2: lenMax = 16'h03ff;
      default: lenMax = 16'h00ff;
    endcase
  endfunction : lenMax

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  initial begin
    mismatches = 0;
    n_compared = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    busReq = '0;
    srcPins = 4'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    chk(4'h0, 16'h0000);
    chk(4'h4, 16'h0000);
    chk(4'h8, 16'h0000);
    chk(4'hc, 16'h0000);
    chk(4'h2, 16'h0000);
    clkEn <= 1'b0;
    wr(4'h8, 16'h1234);
    clkEn <= 1'b1;
    chk(4'h8, 16'h0000);
    for (int l = 0; l < 4; l++) begin
      wr(4'h0, cw(2'h0, 2'h0, 2'h0, 2'(l)));
      wr(4'h8, 16'hffff);
      chk(4'h8, lenMax(2'(l)));
      flags(1'b0, 1'b0);
    end
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, cw(2'h2, 2'h0, 2'(s), 2'h0) | 16'h0100);
      pulse((s + 1) % 4, 2);
      chk(4'h8, 16'h0000);
      pulse(s, 2);
      chk(4'h8, 16'h0002);
    end
    for (int d = 0; d < 4; d++) begin
      wr(4'h0, cw(2'h2, 2'(d), 2'h0, 2'h0) | 16'h0100);
      chk(4'h8, 16'h0000);
      pulse(0, 8);
      chk(4'h8, 16'(8 >> d));
    end
    // A read taken while halted cannot catch the count in mid-step.
    wr(4'h0, cw(2'h0, 2'h0, 2'h0, 2'h0));
    pulse(0, 3);
    chk(4'h8, 16'h0001);
    wr(4'h4, 16'h0003);
    wr(4'hc, 16'h0003);
    wr(4'h0, cw(2'h1, 2'h0, 2'h0, 2'h0) | 16'h0100);
    chk(4'h0, cw(2'h1, 2'h0, 2'h0, 2'h0));
    pulse(0, 3);
    chk(4'h8, 16'h0003);
    flags(1'b1, 1'b0);
    pulse(0, 1);
    chk(4'h8, 16'h0000);
    flags(1'b1, 1'b1);
    chk(4'h4, 16'h0003);
    wr(4'h4, 16'h0003);
    chk(4'h4, 16'h0000);
    wr(4'hc, 16'h0008);
    pulse(0, 5);
    wr(4'hc, 16'h0003);
    pulse(0, 1);
    chk(4'h8, 16'h0000);
    wr(4'h0, cw(2'h0, 2'h0, 2'h0, 2'h0));
    wr(4'h8, 16'h0009);
    wr(4'hc, 16'h0004);
    wr(4'h0, cw(2'h1, 2'h0, 2'h0, 2'h0));
    chk(4'h8, 16'h0000);
    wr(4'hc, 16'h0000);
    wr(4'h8, 16'h0002);
    pulse(0, 2);
    chk(4'h8, 16'h0002);
    wr(4'hc, 16'h0005);
    chk(4'h8, 16'h0000);
    pulse(0, 1);
    chk(4'h8, 16'h0001);
    wr(4'h4, 16'h0003);
    wr(4'h0, cw(2'h2, 2'h0, 2'h0, 2'h3) | 16'h0100);
    wr(4'h8, 16'h00fe);
    pulse(0, 1);
    flags(1'b0, 1'b0);
    pulse(0, 1);
    chk(4'h8, 16'h0000);
    flags(1'b0, 1'b1);
    wr(4'h4, 16'h0003);
    wr(4'hc, 16'h0002);
    wr(4'h0, cw(2'h3, 2'h0, 2'h0, 2'h0) | 16'h0100);
    pulse(0, 1);
    flags(1'b0, 1'b0);
    pulse(0, 1);
    chk(4'h8, 16'h0002);
    flags(1'b1, 1'b0);
    pulse(0, 1);
    chk(4'h8, 16'h0001);
    wr(4'h0, cw(2'h0, 2'h0, 2'h0, 2'h0));
    pulse(0, 2);
    wr(4'h0, cw(2'h3, 2'h0, 2'h0, 2'h0));
    pulse(0, 1);
    chk(4'h8, 16'h0000);
    flags(1'b1, 1'b1);
    pulse(0, 3);
    chk(4'h8, 16'h0001);
    wr(4'h0, cw(2'h3, 2'h0, 2'h0, 2'h0) | 16'h0100);
    chk(4'h8, 16'h0000);
    pulse(0, 1);
    chk(4'h8, 16'h0001);
    // A reset in mid-run must drop the sticky flags and the running setup.
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    flags(1'b0, 1'b0);
    chk(4'h8, 16'h0000);
    chk(4'h0, 16'h0000);
    close_out();
  end
endmodule : pltc_core_tb_top
